// [rtl/srrs_pkg.sv]
// Package: constants and carrier types for the stop/reset supervisor
package srrs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int          CLK_MHZ           = 25;
  localparam int          RST_PIN_MIN_CYC   = 8;       // Reset pin low cycles to count as reset
  localparam int          STARTUP_MS_X10    = 655;     // 65.5 ms start-up wait
  localparam int          STARTUP_EXTRA_CYC = 7;
  localparam int          STARTUP_CYC       = (STARTUP_MS_X10 * CLK_MHZ * 1000) / 10
                                              + STARTUP_EXTRA_CYC;
  localparam int          PF_GLITCH_NS      = 100;     // Power-fail filter time
  localparam int          PF_GLITCH_CYC     = (PF_GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int          STOP_WAKE_MS      = 20;      // Least stop-exit wait
  localparam int          STOP_WAKE_CYC     = STOP_WAKE_MS * CLK_MHZ * 1000;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0]  ADDR_STOP_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_WAKE_EN      = 8'h04;
  localparam logic [7:0]  ADDR_PF_CFG       = 8'h08;
  localparam logic [7:0]  ADDR_SYS_CTRL     = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS       = 8'h10;
  localparam logic [7:0]  ADDR_RESET_VEC    = 8'h14;

  localparam logic [7:0]  STOP_KEY          = 8'h5A;
  localparam logic [7:0]  SLEEP_KEY         = 8'h0F;
  localparam logic [15:0] VEC_LO_ADDR       = 16'hFFFE;
  localparam logic [15:0] VEC_HI_ADDR       = 16'hFFFF;
  localparam logic [15:0] RESET_VEC_DEF     = 16'h0000;

  // Field positions
  localparam int          PF_EN_BIT         = 0;
  localparam int          PF_MODE_BIT       = 1;       // 1 = reset, 0 = freeze
  localparam int          SYS_EXTCLK_BIT    = 0;
  localparam int          SYS_PERI_BIT      = 1;
  localparam int          SYS_BOOST_BIT     = 2;
  localparam int          SYS_SUBCLK_BIT    = 3;
  localparam int          SYS_DPAGE_BIT     = 4;
  localparam int          WAKE_N            = 5;       // ext, watch, key, ec timer, spare

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_STARTUP = 3'b001,
    ST_RUN     = 3'b010,
    ST_STOP    = 3'b011,
    ST_LOWV    = 3'b100
  } srrs_state_t;

  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } srrs_ahb_req_t;

  typedef struct packed {
    logic        core_run;
    logic        main_osc_en;
    logic        xin_tie_low;
    logic        peri_clk_en;
    logic        ports_input;
    logic        freeze;
    logic [15:0] pc_load;
  } srrs_ctrl_t;

endpackage

// [rtl/srrs_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module srrs_sync
  import srrs_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Async input and filtered level
  input  wire logic din,
  output logic      dout
);

  logic [2:0] stage_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_q <= {3{RESET_VAL}};
    end else begin
      stage_q <= {stage_q[1:0], din};
    end
  end

  // Stage zero is read only by stage one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout <= RESET_VAL;
    end else if (stage_q[1] == stage_q[2]) begin
      dout <= stage_q[2];
    end
  end

endmodule

// [rtl/srrs_top.sv]
// Stop-release and reset supervisor with AHB-Lite register slave
// Summary of operation
// - STOP ties oscillator input low; refused with external clock
// - STOP left by reset or listed wakeups
// - Only enabled interrupts wake from STOP
// - Reset exit reinitialises control registers only; the code keeps reset_vec_q
// - Interrupt exit keeps all registers; the code clears stop_armed_q on entry to STOP
// - Start-up wait halts core after release
// - Reset sources: pin, watchdog and power fail
// - Reset loads vector, clears page, defaults clocks
// - Wait 65.5ms plus 7 periods after reset
// - Pin high releases reset, vector FFFE/FFFF; pc_load comes from reset_vec_q instead
// - Power-fail config enables the detector
// - Filtered power fail resets or freezes
// - Supply comparator low enters low-voltage mode
// - Low-voltage mode: no stop release, inputs
// - Reset leaves low-voltage mode normally
// - STOP needs key 5A then stop instruction
// - STOP halts main, system, peripheral clocks
`timescale 1ns/1ps
module srrs_top
  import srrs_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins and monitors
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_rst,
  input  wire logic        stop_instr,
  input  wire logic [WAKE_N-1:0] wake_req,
  input  wire logic        pf_low,
  input  wire logic        supply_low,
  // Core and clock controls
  output srrs_ctrl_t       ctrl,
  output logic [7:0]       ram_page_select
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic                pin_n_s;
  logic                pf_s;
  logic                lv_s;
  logic [WAKE_N-1:0]   wake_s;

  srrs_sync #(.RESET_VAL(1'b1)) u_pin (.hclk(hclk), .hresetn(hresetn),
    .din(reset_pin_n), .dout(pin_n_s));
  srrs_sync #(.RESET_VAL(1'b0)) u_pf (.hclk(hclk), .hresetn(hresetn),
    .din(pf_low), .dout(pf_s));
  srrs_sync #(.RESET_VAL(1'b0)) u_lv (.hclk(hclk), .hresetn(hresetn),
    .din(supply_low), .dout(lv_s));

  genvar gi;
  generate
    for (gi = 0; gi < WAKE_N; gi++) begin : g_wake
      srrs_sync #(.RESET_VAL(1'b0)) u_wk (.hclk(hclk), .hresetn(hresetn),
        .din(wake_req[gi]), .dout(wake_s[gi]));
    end
  endgenerate

  // ****************************************
  // Reset source qualification
  // ****************************************
  logic [3:0] pin_low_cnt_q;
  logic       pin_rst_q;
  logic       pf_rst;
  logic       sys_rst;
  logic [2:0] pf_cnt_q;
  logic       pf_hit_q;
  logic [7:0] pf_cfg_q;

  // Glitches shorter than the minimum width are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_low_cnt_q <= 4'h0;
      pin_rst_q     <= 1'b0;
    end else if (pin_n_s) begin
      pin_low_cnt_q <= 4'h0;
      pin_rst_q     <= 1'b0;
    end else if (pin_low_cnt_q < 4'(RST_PIN_MIN_CYC)) begin
      pin_low_cnt_q <= pin_low_cnt_q + 4'h1;
    end else begin
      pin_rst_q     <= 1'b1;
    end
  end

  // Supply must stay low for the filter time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pf_cnt_q <= 3'h0;
      pf_hit_q <= 1'b0;
    end else if (!pf_s || !pf_cfg_q[PF_EN_BIT]) begin
      pf_cnt_q <= 3'h0;
      pf_hit_q <= 1'b0;
    end else if (pf_cnt_q < 3'(PF_GLITCH_CYC)) begin
      pf_cnt_q <= pf_cnt_q + 3'h1;
    end else begin
      pf_hit_q <= 1'b1;
    end
  end

  assign pf_rst  = pf_hit_q && pf_cfg_q[PF_MODE_BIT];
  assign sys_rst = pin_rst_q || watchdog_rst || pf_rst;

  // ****************************************
  // Sequencer
  // ****************************************
  srrs_state_t state_q;
  logic [31:0] wait_q;
  logic        stop_armed_q;
  logic [WAKE_N-1:0] wake_en_q;
  logic        wake_hit;
  logic [7:0]  sys_ctrl_q;
  logic [15:0] reset_vec_q;

  // Only sources enabled before STOP count; the spare top request never wakes
  assign wake_hit = |(wake_s[WAKE_N-2:0] & wake_en_q[WAKE_N-2:0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_RESET;
      wait_q  <= 32'h0000_0000;
    end else if (sys_rst) begin
      state_q <= ST_RESET;
      wait_q  <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_q <= ST_STARTUP;
          wait_q  <= 32'(STARTUP_CYCLES);
        end
        ST_STARTUP: begin
          if (lv_s) begin
            state_q <= ST_LOWV;
          end else if (wait_q == 32'h0000_0000) begin
            state_q <= ST_RUN;
          end else begin
            wait_q <= wait_q - 32'h0000_0001;
          end
        end
        ST_RUN: begin
          if (lv_s) begin
            state_q <= ST_LOWV;
          end else if (stop_instr && stop_armed_q &&
                       !sys_ctrl_q[SYS_EXTCLK_BIT]) begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (lv_s) begin
            state_q <= ST_LOWV;
          end else if (wake_hit) begin
            state_q <= ST_STARTUP;
            wait_q  <= 32'(STARTUP_CYCLES);
          end
        end
        ST_LOWV: begin
          state_q <= ST_LOWV;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // ****************************************
  // Core control outputs
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
    end else begin
      ctrl.core_run    <= (state_q == ST_RUN) && !pf_hit_q;
      ctrl.freeze      <= pf_hit_q && !pf_cfg_q[PF_MODE_BIT];
      ctrl.main_osc_en <= (state_q != ST_STOP);
      ctrl.xin_tie_low <= (state_q == ST_STOP);
      ctrl.peri_clk_en <= (state_q != ST_STOP) && sys_ctrl_q[SYS_PERI_BIT];
      ctrl.ports_input <= (state_q == ST_LOWV) || (state_q == ST_RESET);
      ctrl.pc_load     <= reset_vec_q;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       acc_ok;

  assign acc_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= acc_ok && hwrite;
      if (acc_ok) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  // Reset exit reloads every control register except reset_vec_q; RAM is outside this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_armed_q <= 1'b0;
      wake_en_q    <= '0;
      pf_cfg_q     <= 8'h00;
      sys_ctrl_q   <= 8'h02;
      ram_page_select <= 8'h00;
      reset_vec_q  <= RESET_VEC_DEF;
    end else if (state_q == ST_RESET) begin
      stop_armed_q <= 1'b0;
      wake_en_q    <= '0;
      pf_cfg_q     <= 8'h00;
      sys_ctrl_q   <= 8'h02;
      ram_page_select <= 8'h00;
    end else begin
      if (state_q == ST_STOP) begin
        stop_armed_q <= 1'b0;
      end
      if (wr_pend_q) begin
        unique case (wr_addr_q)
          ADDR_STOP_CTRL: stop_armed_q <= (hwdata[7:0] == STOP_KEY);
          ADDR_WAKE_EN:   wake_en_q    <= hwdata[WAKE_N-1:0];
          ADDR_PF_CFG:    pf_cfg_q     <= hwdata[7:0];
          ADDR_SYS_CTRL:  sys_ctrl_q   <= hwdata[7:0];
          ADDR_RESET_VEC: reset_vec_q  <= hwdata[15:0];
          default:        ram_page_select <= ram_page_select;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_ok && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_STOP_CTRL: hrdata <= {31'h0, stop_armed_q};
        ADDR_WAKE_EN:   hrdata <= {27'h0, wake_en_q};
        ADDR_PF_CFG:    hrdata <= {24'h0, pf_cfg_q};
        ADDR_SYS_CTRL:  hrdata <= {24'h0, sys_ctrl_q};
        ADDR_STATUS:    hrdata <= {26'h0, pf_hit_q, lv_s, pin_rst_q, state_q};
        ADDR_RESET_VEC: hrdata <= {16'h0, reset_vec_q};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// [verification/srrs_top_asserts.sv]
// Checker: timing relations at the supervisor ports
`timescale 1ns/1ps
module srrs_top_asserts
  import srrs_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  // Clock and reset
  input logic              hclk,
  input logic              hresetn,
  // Bus answer
  input logic              hreadyout,
  input logic              hresp,
  // Sources and controls
  input logic              reset_pin_n,
  input logic              watchdog_rst,
  input logic [WAKE_N-1:0] wake_req,
  input logic              supply_low,
  input srrs_ctrl_t        ctrl,
  input logic [7:0]        ram_page_select
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Cycles spent with the core halted
  int low_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_q <= 0;
    else if (ctrl.core_run) low_q <= 0;
    else low_q <= low_q + 1;
  end

  AST_READY: assert property (hreadyout) else $error("hreadyout low");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_STOP_OSC: assert property (ctrl.xin_tie_low |-> !ctrl.main_osc_en)
    else $error("oscillator runs with input tied");
  AST_STOP_CLK: assert property (ctrl.xin_tie_low |-> !ctrl.core_run && !ctrl.peri_clk_en)
    else $error("clocks run in stop");
  AST_STOP_HOLD: assert property (
    (ctrl.xin_tie_low && wake_req == '0 && reset_pin_n && !watchdog_rst)[*6]
    |=> ctrl.xin_tie_low) else $error("stop left without cause");
  // Leaving a power-fail freeze is not a release, so it needs no start-up wait
  AST_STARTUP: assert property (
    $rose(ctrl.core_run) && !$past(ctrl.freeze) |-> low_q >= STARTUP_CYCLES)
    else $error("start-up wait too short");
  AST_PIN_RST: assert property (!reset_pin_n[*8] ##1 !reset_pin_n[*8]
    |-> ##[0:4] !ctrl.core_run) else $error("pin reset ignored");
  AST_WDOG: assert property (watchdog_rst |-> ##[1:4] !ctrl.core_run)
    else $error("watchdog reset ignored");
  AST_LOWV: assert property (supply_low[*8] |-> ##[0:4] ctrl.ports_input)
    else $error("low supply not detected");
  AST_RST_INIT: assert property ($rose(hresetn) |-> ram_page_select == 8'h00
    && !ctrl.core_run) else $error("reset state wrong");
endmodule

bind srrs_top srrs_top_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .reset_pin_n(reset_pin_n), .watchdog_rst(watchdog_rst), .wake_req(wake_req),
  .supply_low(supply_low), .ctrl(ctrl), .ram_page_select(ram_page_select)
);

// [verification/srrs_env_model.sv]
// Partner model: reset circuit, wake sources and supply monitors
`timescale 1ns/1ps
module srrs_env_model
  import srrs_pkg::*;
(
  // Clock
  input wire logic          hclk,
  // Reset sources
  output logic              reset_pin_n,
  output logic              watchdog_rst,
  // Wake requests and supply monitors
  output logic [WAKE_N-1:0] wake_req,
  output logic              pf_low,
  output logic              supply_low
);
  initial begin
    reset_pin_n = 1'b1;
    watchdog_rst = 1'b0;
    wake_req = '0;
    pf_low = 1'b0;
    supply_low = 1'b0;
  end

  // Source s active for n cycles; every source, pin included, released after n
  task automatic act(input int s, input int n);
    case (s)
      0: reset_pin_n <= 1'b0;
      1: watchdog_rst <= 1'b1;
      2: pf_low <= 1'b1;
      3: supply_low <= 1'b1;
      default: wake_req[s-4] <= 1'b1;
    endcase
    repeat (n) @(posedge hclk);
    reset_pin_n <= 1'b1;
    watchdog_rst <= 1'b0;
    pf_low <= 1'b0;
    supply_low <= 1'b0;
    wake_req <= '0;
  endtask
endmodule

// [verification/srrs_top_tb.sv]
// Testbench: bus, stop and wake, reset and supply scenarios
`timescale 1ns/1ps
module srrs_top_tb
  import srrs_pkg::*;
;
  // Short start-up keeps the run brief
  localparam int STUP = 20;
  logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic              stop_instr = 1'b0, rd_pend = 1'b0;
  logic [31:0]       haddr = '0, hwdata = '0, hrdata, rv;
  logic [1:0]        htrans = 2'b00;
  logic [2:0]        hsize = 3'b010;
  logic              hreadyout, hresp, reset_pin_n, watchdog_rst, pf_low, supply_low;
  logic [WAKE_N-1:0] wake_req;
  logic [7:0]        ram_page_select;
  srrs_ctrl_t        ctrl;
  logic [31:0]       expq[$];
  int                mismatches = 0, checks = 0;

  always #20 hclk = ~hclk;

  srrs_env_model i_env (.hclk(hclk), .reset_pin_n(reset_pin_n), .watchdog_rst(watchdog_rst),
    .wake_req(wake_req), .pf_low(pf_low), .supply_low(supply_low));
  srrs_top #(.STARTUP_CYCLES(STUP)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reset_pin_n(reset_pin_n), .watchdog_rst(watchdog_rst), .stop_instr(stop_instr),
    .wake_req(wake_req), .pf_low(pf_low), .supply_low(supply_low), .ctrl(ctrl),
    .ram_page_select(ram_page_select));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Read data is taken at the edge that closes the data phase
  always @(posedge hclk) if (rd_pend) chk("hrdata", hrdata, expq.pop_front());

  // For a read, d is the expected word
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    if (!w) begin
      expq.push_back(d);
      rd_pend <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_pend <= 1'b0;
  endtask

  task wait_run(input logic v);
    for (int i = 0; i < 400 && ctrl.core_run !== v; i++) @(negedge hclk);
    chk("core_run", ctrl.core_run, v);
    @(posedge hclk);
  endtask

  // Sampled away from the edge: 0 freeze, 1 ports_input, 2 xin_tie_low
  task probe(input int s, input logic e);
    @(negedge hclk);
    chk("ctrl", s == 0 ? ctrl.freeze : s == 1 ? ctrl.ports_input : ctrl.xin_tie_low, e);
    @(posedge hclk);
  endtask

  task pulse_stop;
    stop_instr <= 1'b1;
    @(posedge hclk);
    stop_instr <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  initial begin
    void'($urandom(32'h6bf3_746e));
    chk("stop_wait", 32'(STARTUP_CYC > STOP_WAKE_CYC), 32'h0000_0001);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_run(1'b1);
    chk("page", ram_page_select, 32'h0000_0000);
    bus(0, ADDR_SYS_CTRL, 32'h0000_0002);
    bus(0, ADDR_WAKE_EN, 32'h0000_0000);
    bus(0, ADDR_PF_CFG, 32'h0000_0000);
    bus(0, 8'h18, 32'h0000_0000);
    bus(0, ADDR_STATUS, 32'h0000_0002);
    rv = {16'h0000, 16'($urandom)};
    bus(1, ADDR_RESET_VEC, rv);
    bus(0, ADDR_RESET_VEC, rv);
    pulse_stop;
    bus(0, ADDR_STATUS, 32'h0000_0002);
    bus(1, ADDR_SYS_CTRL, 32'h0000_0003);
    bus(1, ADDR_STOP_CTRL, {24'h00_0000, STOP_KEY});
    pulse_stop;
    bus(0, ADDR_STATUS, 32'h0000_0002);
    bus(1, ADDR_SYS_CTRL, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      bus(1, ADDR_WAKE_EN, 32'h1 << i);
      bus(1, ADDR_STOP_CTRL, {24'h00_0000, STOP_KEY});
      pulse_stop;
      probe(2, 1'b1);
      bus(0, ADDR_STATUS, 32'h0000_0003);
      i_env.act(4 + (i + 1) % 4, 10);
      bus(0, ADDR_STATUS, 32'h0000_0003);
      fork
        i_env.act(4 + i, 60);
        wait_run(1'b1);
      join
      bus(0, ADDR_WAKE_EN, 32'h1 << i);
    end
    // Spare request is enabled but must not end STOP; the watchdog ends it
    bus(1, ADDR_WAKE_EN, 32'h0000_0010);
    bus(1, ADDR_STOP_CTRL, {24'h00_0000, STOP_KEY});
    pulse_stop;
    i_env.act(8, 10);
    bus(0, ADDR_STATUS, 32'h0000_0003);
    i_env.act(1, 2);
    wait_run(1'b0);
    wait_run(1'b1);
    bus(0, ADDR_WAKE_EN, 32'h0000_0000);
    i_env.act(2, 10);
    bus(0, ADDR_STATUS, 32'h0000_0002);
    bus(1, ADDR_PF_CFG, 32'h0000_0003);
    i_env.act(2, 10);
    wait_run(1'b0);
    wait_run(1'b1);
    bus(0, ADDR_PF_CFG, 32'h0000_0000);
    bus(1, ADDR_PF_CFG, 32'h0000_0001);
    i_env.act(2, 10);
    probe(0, 1'b1);
    i_env.act(0, 20);
    wait_run(1'b0);
    wait_run(1'b1);
    probe(0, 1'b0);
    i_env.act(3, 15);
    probe(1, 1'b1);
    i_env.act(0, 20);
    wait_run(1'b1);
    probe(1, 1'b0);
    end_sim;
  end

  // Run needs about 600 cycles
  initial begin
    repeat (6000) @(posedge hclk);
    mismatches++;
    end_sim;
  end
endmodule
